// ==== rtl/desc_sync_timer.sv ====
`timescale 1ns/10ps
module desc_sync_timer #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned SHORT_CYC = 14440,
  parameter int unsigned LONG_CYC = 40000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // control
  input wire logic long_sel_in,
  input wire logic bypass_in,
  // descrambler events
  input wire logic sync_event_in,
  // result
  output logic locked_out
);

  logic [CNT_W-1:0] idle_cnt_ff;
  logic locked_ff;
  logic [CNT_W-1:0] limit;

  if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC || LONG_CYC >= (64'd1 << CNT_W)) begin : g_chk
    $error("desc_sync_timer: timeout counts do not fit");
  end

  // timeout selection
  assign limit = long_sel_in ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      idle_cnt_ff <= '0;
      locked_ff <= 1'b0;
    end else if (sync_event_in || bypass_in) begin
      idle_cnt_ff <= '0;
      locked_ff <= 1'b1;
    end else if (locked_ff) begin
      if (idle_cnt_ff >= limit) begin
        locked_ff <= 1'b0;
        idle_cnt_ff <= '0;
      end else begin
        idle_cnt_ff <= idle_cnt_ff + CNT_W'(1);
      end
    end
  end

  assign locked_out = locked_ff;

endmodule

// ==== rtl/pcs_100m_config_register.sv ====
// Implementation choice: the APB register port.
`timescale 1ns/10ps
module pcs_100m_config_register
  #(
  parameter int unsigned TIMER_W = 16,
  parameter int unsigned DESC_SHORT_CYC = pcs_cfg_pkg::DESC_TIMEOUT_SHORT_CYC,
  parameter int unsigned DESC_LONG_CYC = pcs_cfg_pkg::DESC_TIMEOUT_LONG_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [pcs_cfg_pkg::APB_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // configuration strap pin
  input wire logic fiber_strap_in,
  // line side status from the receive path
  input wire logic signal_level_valid_in,
  input wire logic descrambler_sync_event_in,
  input wire logic symbol_align_in,
  // control outputs
  output logic rx_clk_free_run_out,
  output logic rx_clk_realign_out,
  output logic quiet_transmit_out,
  output logic signal_detect_out,
  output logic fiber_mode_out,
  output logic far_end_fault_out,
  output logic nrzi_bypass_out,
  output logic scrambler_bypass_out,
  output logic descrambler_bypass_out,
  // link status
  output logic descrambler_locked_out,
  output logic link_100_good_out
);
  import pcs_cfg_pkg::*;

  if (TIMER_W < 2 || TIMER_W > 32) begin : g_chk
    $error("pcs_100m_config_register: TIMER_W out of range");
  end

  if (DESC_SHORT_CYC < 1 || DESC_LONG_CYC < DESC_SHORT_CYC ||
      DESC_LONG_CYC >= (64'd1 << TIMER_W)) begin : g_cnt_chk
    $error("pcs_100m_config_register: timeout counts do not fit TIMER_W");
  end

  // the strap filter needs four edges before its level is settled
  if (STRAP_SETTLE_CYC < 4) begin : g_settle_chk
    $error("pcs_100m_config_register: strap window shorter than the filter");
  end

  localparam int unsigned SETTLE_W = $clog2(STRAP_SETTLE_CYC + 1);

  function automatic logic is_cfg_addr(input logic [APB_ADDR_W-1:0] addr);
    return addr == PCS_CFG_ADDR;
  endfunction

  function automatic logic is_stat_addr(input logic [APB_ADDR_W-1:0] addr);
    return addr == LINK_STAT_ADDR;
  endfunction

  function automatic logic [15:0] lane_mask(input logic [3:0] strb);
    return {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic [15:0] merge_bits(input logic [15:0] old, input logic [15:0] val,
                                             input logic [15:0] mask);
    return (old & ~mask) | (val & mask);
  endfunction

  function automatic logic is_bad_access(input logic write, input logic [APB_ADDR_W-1:0] addr);
    if (write) begin
      return !is_cfg_addr(addr);
    end
    return !(is_cfg_addr(addr) || is_stat_addr(addr));
  endfunction

  // state
  logic [15:0] cfg_ff;
  logic [15:0] nxt_cfg;
  logic strap_s1_ff;
  logic strap_s2_ff;
  logic strap_s3_ff;
  logic strap_val_ff;
  logic [SETTLE_W-1:0] settle_cnt_ff;
  logic strap_done_ff;
  logic strap_load;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  link_state_t link_state_ff;
  link_state_t nxt_link_state;
  logic link_good_ff;
  logic sig_detect_ff;
  logic realign_ff;
  logic desc_locked;
  logic sig_ok;
  logic access_go;
  logic write_go;
  logic [15:0] wr_mask;
  logic [15:0] stat_word;

  // strap synchroniser, three stages
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_s1_ff <= 1'b0;
      strap_s2_ff <= 1'b0;
      strap_s3_ff <= 1'b0;
    end else begin
      strap_s1_ff <= fiber_strap_in;
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
    end
  end

  // filtered strap level, changes once stages two and three agree
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_val_ff <= 1'b0;
    end else if (strap_s2_ff == strap_s3_ff) begin
      strap_val_ff <= strap_s3_ff;
    end
  end

  // strap capture window after reset release
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      settle_cnt_ff <= '0;
      strap_done_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      if (strap_load) begin
        strap_done_ff <= 1'b1;
      end else begin
        settle_cnt_ff <= settle_cnt_ff + SETTLE_W'(1);
      end
    end
  end

  // last edge of the window loads the strap bits, after the filter has settled
  assign strap_load = !strap_done_ff && settle_cnt_ff == SETTLE_W'(STRAP_SETTLE_CYC);

  // apb handshake
  assign access_go = psel_in && penable_in && !pready_ff && strap_done_ff;
  assign write_go = psel_in && penable_in && pready_ff && pwrite_in;
  assign wr_mask = CFG_WRITABLE_MASK & lane_mask(pstrb_in);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= access_go;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pslverr_ff <= 1'b0;
    end else if (access_go) begin
      pslverr_ff <= is_bad_access(pwrite_in, paddr_in);
    end else begin
      pslverr_ff <= 1'b0;
    end
  end

  // status word
  always_comb begin
    stat_word = '0;
    stat_word[STAT_LINK_BIT] = link_good_ff;
    stat_word[STAT_LOCK_BIT] = desc_locked;
    stat_word[STAT_SIGNAL_BIT] = sig_detect_ff;
    stat_word[STAT_STRAP_BIT] = strap_val_ff;
    stat_word[STAT_STRAP_DONE_BIT] = strap_done_ff;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_ff <= '0;
    end else if (access_go && !pwrite_in) begin
      if (is_cfg_addr(paddr_in)) begin
        prdata_ff <= {16'h0000, cfg_ff & CFG_WRITABLE_MASK};
      end else if (is_stat_addr(paddr_in)) begin
        prdata_ff <= {16'h0000, stat_word};
      end else begin
        prdata_ff <= '0;
      end
    end else begin
      prdata_ff <= '0;
    end
  end

  // configuration register next value
  always_comb begin
    nxt_cfg = cfg_ff;
    // the bus stalls until capture, so a write never meets the strap load
    if (strap_load) begin
      nxt_cfg = merge_bits(cfg_ff, {16{strap_val_ff}}, CFG_STRAP_MASK);
    end else if (write_go && is_cfg_addr(paddr_in)) begin
      nxt_cfg = merge_bits(cfg_ff, pwdata_in[15:0], wr_mask);
    end
  end

  // strap bits: fiber mode, far-end fault, scrambler and descrambler bypass
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_ff <= CFG_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // descrambler lock with selectable timeout
  desc_sync_timer #(
    .CNT_W(TIMER_W),
    .SHORT_CYC(DESC_SHORT_CYC),
    .LONG_CYC(DESC_LONG_CYC)
  ) u_desc_timer (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .long_sel_in(cfg_ff[DESC_TMO_SEL_BIT]),
    .bypass_in(cfg_ff[DESCR_BYP_BIT]),
    .sync_event_in(descrambler_sync_event_in),
    .locked_out(desc_locked)
  );

  // signal detect with force
  assign sig_ok = signal_level_valid_in || cfg_ff[FORCE_SD_BIT];

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sig_detect_ff <= 1'b0;
    end else begin
      sig_detect_ff <= sig_ok;
    end
  end

  // link qualification
  always_comb begin
    nxt_link_state = link_state_ff;
    case (link_state_ff)
      LINK_DOWN: begin
        if (sig_ok && desc_locked) begin
          nxt_link_state = LINK_UP;
        end
      end
      LINK_UP: begin
        if (!sig_ok) begin
          nxt_link_state = LINK_DOWN;
        end else if (!cfg_ff[DETECT_ALG_BIT] && !desc_locked) begin
          nxt_link_state = LINK_DOWN;
        end
      end
      default: begin
        nxt_link_state = LINK_DOWN;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link_state_ff <= LINK_DOWN;
    end else begin
      link_state_ff <= nxt_link_state;
    end
  end

  // reported link, forced good when asked
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link_good_ff <= 1'b0;
    end else begin
      link_good_ff <= (nxt_link_state == LINK_UP) || cfg_ff[FORCE_LINK_BIT];
    end
  end

  // receive clock realign strobe, suppressed when free running
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      realign_ff <= 1'b0;
    end else begin
      realign_ff <= symbol_align_in && !cfg_ff[RX_FREE_BIT];
    end
  end

  // outputs
  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign rx_clk_free_run_out = cfg_ff[RX_FREE_BIT];
  assign rx_clk_realign_out = realign_ff;
  assign quiet_transmit_out = cfg_ff[QUIET_TX_BIT];
  assign signal_detect_out = sig_detect_ff;
  assign fiber_mode_out = cfg_ff[FIBER_BIT];
  assign far_end_fault_out = cfg_ff[FEFI_BIT];
  assign nrzi_bypass_out = cfg_ff[NRZI_BYP_BIT];
  assign scrambler_bypass_out = cfg_ff[SCR_BYP_BIT];
  assign descrambler_bypass_out = cfg_ff[DESCR_BYP_BIT];
  assign descrambler_locked_out = desc_locked;
  assign link_100_good_out = link_good_ff;

endmodule

// ==== rtl/pcs_cfg_pkg.sv ====
// How it works
// - bits 15:12 and bit 4 ignore writes and read back as zero
// - rx clock mode bit 11 set gives free-running clock, clear follows symbol alignment
// - quiet transmit bit 10 set puts the 100 Mb/s transmitter in true quiet mode
// - force detect bit 9 set holds signal detect asserted inside the attachment sublayer
// - algorithm bit 8 set: link up on signal and lock, held while signal valid
// - algorithm bit 8 clear: link drops on invalid signal or lost descrambler lock
// - descrambler timeout is 722 us with bit 7 clear, 2 ms with it set
// - fiber mode bit 6 resets from the fiber strap and is writable afterwards
// - forced link bit 5 set reports good 100 Mb/s link whatever the line does
// - far-end fault enable bit 3 resets from the fiber strap, writable afterwards
// - fiber strap also brings scrambler and descrambler bypass bits up set
package pcs_cfg_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned DESC_TIMEOUT_SHORT_NS = 722000;
  localparam int unsigned DESC_TIMEOUT_LONG_NS = 2000000;
  localparam int unsigned DESC_TIMEOUT_SHORT_CYC = DESC_TIMEOUT_SHORT_NS / CLK_PERIOD_NS;
  localparam int unsigned DESC_TIMEOUT_LONG_CYC = DESC_TIMEOUT_LONG_NS / CLK_PERIOD_NS;
  localparam int unsigned STRAP_SETTLE_CYC = 4;

  // bus map
  localparam int unsigned APB_ADDR_W = 12;
  localparam logic [7:0] PCS_CFG_INDEX = 8'h16;
  localparam logic [11:0] PCS_CFG_ADDR = {2'h0, PCS_CFG_INDEX, 2'h0};
  localparam logic [11:0] LINK_STAT_ADDR = 12'h080;

  // configuration register fields
  localparam int unsigned RX_FREE_BIT = 11;
  localparam int unsigned QUIET_TX_BIT = 10;
  localparam int unsigned FORCE_SD_BIT = 9;
  localparam int unsigned DETECT_ALG_BIT = 8;
  localparam int unsigned DESC_TMO_SEL_BIT = 7;
  localparam int unsigned FIBER_BIT = 6;
  localparam int unsigned FORCE_LINK_BIT = 5;
  localparam int unsigned FEFI_BIT = 3;
  localparam int unsigned NRZI_BYP_BIT = 2;
  localparam int unsigned SCR_BYP_BIT = 1;
  localparam int unsigned DESCR_BYP_BIT = 0;
  localparam logic [15:0] CFG_WRITABLE_MASK = 16'h0fef;
  localparam logic [15:0] CFG_RESET = 16'h0100;
  localparam logic [15:0] CFG_STRAP_MASK = 16'h004b;

  // link status register fields
  localparam int unsigned STAT_LINK_BIT = 0;
  localparam int unsigned STAT_LOCK_BIT = 1;
  localparam int unsigned STAT_SIGNAL_BIT = 2;
  localparam int unsigned STAT_STRAP_BIT = 3;
  localparam int unsigned STAT_STRAP_DONE_BIT = 4;

  typedef enum logic [1:0] {
    LINK_DOWN = 2'b01,
    LINK_UP = 2'b10
  } link_state_t;

endpackage

// ==== verification/pcs_cfg_monitor.sv ====
`timescale 1ns/10ps
module pcs_cfg_monitor #(
  parameter int unsigned DESC_LONG_CYC = 40000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // bus
  input wire logic pwrite_in,
  input wire logic [pcs_cfg_pkg::APB_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // line side
  input wire logic signal_level_valid_in,
  input wire logic descrambler_sync_event_in,
  // controls
  input wire logic rx_clk_free_run_out,
  input wire logic quiet_transmit_out,
  input wire logic signal_detect_out,
  input wire logic fiber_mode_out,
  input wire logic far_end_fault_out,
  input wire logic scrambler_bypass_out,
  input wire logic descrambler_bypass_out,
  input wire logic descrambler_locked_out
);
  import pcs_cfg_pkg::*;
  logic [31:0] idle_ff;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // cycles without sync event or bypass
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      idle_ff <= '0;
    else if (descrambler_sync_event_in || descrambler_bypass_out)
      idle_ff <= '0;
    else if (idle_ff < 32'h0000ffff)
      idle_ff <= idle_ff + 32'h1;
  end
  sequence cfg_read;
    pready_out && !pwrite_in && paddr_in == PCS_CFG_ADDR;
  endsequence
  a_reserved_zero: assert property (cfg_read |-> prdata_out[15:12] == 4'h0 && !prdata_out[4])
    else $error("reserved bits nonzero");
  a_free_run_read: assert property (cfg_read |-> prdata_out[11] == rx_clk_free_run_out)
    else $error("free run output mismatch");
  a_quiet_read: assert property (cfg_read |-> prdata_out[10] == quiet_transmit_out)
    else $error("quiet output mismatch");
  a_detect_follow: assert property (signal_level_valid_in |=> signal_detect_out)
    else $error("signal detect missing");
  a_strap_bits_read: assert property (cfg_read |->
    prdata_out[6] == fiber_mode_out && prdata_out[3] == far_end_fault_out)
    else $error("fiber or fault output mismatch");
  a_bypass_read: assert property (cfg_read |->
    prdata_out[1:0] == {scrambler_bypass_out, descrambler_bypass_out})
    else $error("bypass output mismatch");
  a_lock_on_event: assert property (descrambler_sync_event_in |=> descrambler_locked_out)
    else $error("lock not set");
  a_lock_timeout: assert property (idle_ff > DESC_LONG_CYC + 2 |-> !descrambler_locked_out)
    else $error("lock held too long");
  a_pready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
endmodule

// ==== verification/tb_pcs_100m_config_register.sv ====
`timescale 1ns/10ps
bind pcs_100m_config_register pcs_cfg_monitor #(.DESC_LONG_CYC(DESC_LONG_CYC)) mon (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .signal_level_valid_in(signal_level_valid_in),
  .descrambler_sync_event_in(descrambler_sync_event_in),
  .rx_clk_free_run_out(rx_clk_free_run_out), .quiet_transmit_out(quiet_transmit_out),
  .signal_detect_out(signal_detect_out), .fiber_mode_out(fiber_mode_out),
  .far_end_fault_out(far_end_fault_out), .scrambler_bypass_out(scrambler_bypass_out),
  .descrambler_bypass_out(descrambler_bypass_out),
  .descrambler_locked_out(descrambler_locked_out));
module tb_pcs_100m_config_register;
  import pcs_cfg_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in, psel_in, penable_in, pwrite_in, fiber_strap_in, sl, ev, al, rerr;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rdat;
  logic pready_out, pslverr_out, frc, rea, qt, sd, fm, fef, nb, sb, db, lk, lg;
  logic [3:0] strb;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  pcs_100m_config_register #(.DESC_SHORT_CYC(20), .DESC_LONG_CYC(50)) DUT (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(strb),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .fiber_strap_in(fiber_strap_in), .signal_level_valid_in(sl),
    .descrambler_sync_event_in(ev), .symbol_align_in(al), .rx_clk_free_run_out(frc),
    .rx_clk_realign_out(rea), .quiet_transmit_out(qt), .signal_detect_out(sd),
    .fiber_mode_out(fm), .far_end_fault_out(fef), .nrzi_bypass_out(nb),
    .scrambler_bypass_out(sb), .descrambler_bypass_out(db),
    .descrambler_locked_out(lk), .link_100_good_out(lg));
  always #25 clk_in = ~clk_in;
  task finish_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      finish_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {16'h0000, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rdat = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [15:0] d);
    apb(1'b1, PCS_CFG_ADDR, d);
  endtask
  task automatic rdc(input logic [15:0] e);
    apb(1'b0, PCS_CFG_ADDR, 16'h0000);
    chk(rdat, {16'h0000, e});
  endtask
  task automatic pulse(input logic sym);
    if (sym)
      al <= 1'b1;
    else
      ev <= 1'b1;
    @(posedge clk_in);
    al <= 1'b0;
    ev <= 1'b0;
  endtask
  task automatic rst(input logic s);
    fiber_strap_in <= s;
    arst_n_in <= 1'b0;
    cyc(6);
    arst_n_in <= 1'b1;
  endtask
  initial begin
    {arst_n_in, psel_in, penable_in, pwrite_in, fiber_strap_in, sl, ev, al} = 8'h00;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    strb = 4'hf;
    rst(1'b0);
    rdc(16'h0100);
    apb(1'b0, LINK_STAT_ADDR, 16'h0000);
    chk(rdat, 32'h10);
    wr(16'hffff);
    rdc(16'h0fef);
    chk({frc, qt, fm, fef, nb, sb, db}, 32'h7f);
    pulse(1'b1);
    @(posedge clk_in);
    chk(rea, 32'h0);
    wr(16'h0000);
    rdc(16'h0000);
    chk({frc, qt, fm, fef, nb, sb, db}, 32'h0);
    pulse(1'b1);
    @(posedge clk_in);
    chk(rea, 32'h1);
    apb(1'b1, 12'h100, 16'hffff);
    chk(rerr, 32'h1);
    rdc(16'h0000);
    strb <= 4'h1;
    wr(16'hffff);
    rdc(16'h00ef);
    strb <= 4'hf;
    $display("test registers done");
    wr(16'h0100);
    sl <= 1'b1;
    pulse(1'b0);
    cyc(5);
    chk(lg, 32'h1);
    cyc(60);
    chk({lk, lg}, 32'h1);
    wr(16'h0000);
    cyc(3);
    chk(lg, 32'h0);
    pulse(1'b0);
    cyc(5);
    chk(lg, 32'h1);
    sl <= 1'b0;
    cyc(3);
    chk(lg, 32'h0);
    $display("test link done");
    pulse(1'b0);
    cyc(15);
    chk(lk, 32'h1);
    cyc(10);
    chk(lk, 32'h0);
    wr(16'h0080);
    pulse(1'b0);
    cyc(35);
    chk(lk, 32'h1);
    cyc(25);
    chk(lk, 32'h0);
    $display("test timeout done");
    wr(16'h0200);
    cyc(2);
    chk(sd, 32'h1);
    wr(16'h0020);
    cyc(2);
    chk({sd, lg}, 32'h1);
    wr(16'h0000);
    cyc(2);
    chk(lg, 32'h0);
    $display("test force done");
    rst(1'b1);
    rdc(16'h014b);
    chk(lk, 32'h1);
    apb(1'b0, LINK_STAT_ADDR, 16'h0000);
    chk(rdat, 32'h1a);
    wr(16'h0000);
    rdc(16'h0000);
    $display("test strap done");
    finish_test;
  end
endmodule
